// ===== rtl/scmc_regs.svh
`ifndef SCMC_REGS_SVH
`define SCMC_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCMC_CLK_NS 40
`define SCMC_UV_FLT_NS 10000
`define SCMC_OV_FLT_NS 100000
`define SCMC_ENDR_FLT_NS 1000
`define SCMC_UV_FLT_CYC (`SCMC_UV_FLT_NS / `SCMC_CLK_NS)
`define SCMC_OV_FLT_CYC (`SCMC_OV_FLT_NS / `SCMC_CLK_NS)
`define SCMC_ENDR_FLT_CYC (`SCMC_ENDR_FLT_NS / `SCMC_CLK_NS)

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCMC_OFS_FAULT 8'h00
`define SCMC_OFS_SVCEN 8'h04
`define SCMC_OFS_DRVEN 8'h08
`define SCMC_OFS_CHCFG 8'h0C
`define SCMC_OFS_OCTH 8'h10
`define SCMC_OFS_STAT 8'h14
`define SCMC_OFS_IRQST 8'h18
`define SCMC_OFS_IRQCLR 8'h1C
`define SCMC_OFS_IRQEN 8'h20
`define SCMC_OFS_TGT0 8'h40

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SCMC_FLT_OV 1
`define SCMC_FLT_UV 2
`define SCMC_SVC_FSPD 6
`define SCMC_SVC_PUMP 7
`define SCMC_CFG_SRC 8
`define SCMC_CFG_RNG 16
`define SCMC_TGT_PER 16
`define SCMC_STAT_UV 8
`define SCMC_STAT_OV 9
`define SCMC_STAT_ENDR 10
`define SCMC_IRQ_UV 0
`define SCMC_IRQ_OV 1
`define SCMC_IRQ_REJ 2
`define SCMC_IRQ_W 3
`define SCMC_RST_PER 11'h00C

`endif

// ===== rtl/scmc_pkg.sv
package scmc_pkg;
	typedef enum logic [1:0] {
		SCMC_SUP_RUN,
		SCMC_SUP_UV,
		SCMC_SUP_OV
	} scmc_sup_t;
endpackage

// ===== rtl/scmc_top.sv
`timescale 1ns/10ps
`include "scmc_regs.svh"

// ----------------------------------------
// Persistence filter
// ----------------------------------------
module scmc_filt #(
	parameter int N = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	localparam int CW = $clog2(N + 1);
	logic [CW-1:0] cnt_q;
	logic out_q;

	assign dout = out_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else if (din == out_q) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(N - 1)) begin
			cnt_q <= '0;
			out_q <= din;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule

// ----------------------------------------
// Channel mode control
// ----------------------------------------
module scmc_top #(
	parameter int NCH = 6,
	parameter int SPW = 11
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic supply_undervoltage,
	input wire logic supply_overvoltage,
	input wire logic driver_enable_input,
	input wire logic config_pin,
	input wire logic wd_permit,
	input wire logic [NCH-1:0] channel_drive_input,
	input wire logic [NCH-1:0] current_low,
	output logic [NCH-1:0] ch_active,
	output logic [NCH-1:0] hs_gate,
	output logic [NCH-1:0] ls_gate,
	output logic fs_predrv_en,
	output logic pump_predrv_en,
	output logic ls_clamp_en,
	output logic [NCH-1:0] cur_range,
	output logic [2*NCH-1:0] oc_thresh,
	output logic [NCH*SPW-1:0] tgt_current
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	scmc_pkg::scmc_sup_t st_q, st_d;
	logic uv_f, ov_f, endr_f;
	logic wait_q, irq_q;
	logic [31:0] rdata_q, rd_mux;
	logic [2:1] flt_q;
	logic [`SCMC_IRQ_W-1:0] ist_q, ien_q, ist_d;
	logic [NCH-1:0] en_q, drven_q, side_q, src_q, rng_q;
	logic [NCH-1:0] side_d, src_d, rng_d;
	logic [2*NCH-1:0] oc_q, oc_d;
	logic fspd_q, pump_q, clamp_q;
	logic [NCH*SPW-1:0] setpt_q;
	logic [SPW-1:0] per_q [NCH];
	logic [SPW-1:0] pcnt_q [NCH];
	logic [NCH-1:0] pwm_q, act_q, act_d, drv, hs_q, ls_q, hs_out_q, ls_out_q;
	logic rej_side, rej_lock;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic tgt_hit(input logic [7:0] a, input int ch);
		return a == 8'(`SCMC_OFS_TGT0 + 4 * ch);
	endfunction

	// ----------------------------------------
	// Filters
	// ----------------------------------------
	scmc_filt #(.N(`SCMC_UV_FLT_CYC)) u_uv_flt (.mclk(mclk), .reset(reset),
		.din(supply_undervoltage), .dout(uv_f));
	scmc_filt #(.N(`SCMC_OV_FLT_CYC)) u_ov_flt (.mclk(mclk), .reset(reset),
		.din(supply_overvoltage), .dout(ov_f));
	// Short deglitch: a spike must not enable drivers
	scmc_filt #(.N(`SCMC_ENDR_FLT_CYC)) u_endr_flt (.mclk(mclk), .reset(reset),
		.din(driver_enable_input), .dout(endr_f));

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire acc = (avs_read | avs_write) & ~wait_q;
	wire wr = avs_write & acc;
	wire rd = avs_read & acc;
	wire sel_flt = avs_address == `SCMC_OFS_FAULT;
	wire sel_svc = avs_address == `SCMC_OFS_SVCEN;
	wire sel_drv = avs_address == `SCMC_OFS_DRVEN;
	wire sel_cfg = avs_address == `SCMC_OFS_CHCFG;
	wire sel_oc = avs_address == `SCMC_OFS_OCTH;
	wire sel_stat = avs_address == `SCMC_OFS_STAT;
	wire sel_ist = avs_address == `SCMC_OFS_IRQST;
	wire sel_iclr = avs_address == `SCMC_OFS_IRQCLR;
	wire sel_ien = avs_address == `SCMC_OFS_IRQEN;
	wire [31:0] wd = avs_writedata;
	wire [NCH-1:0] wd_side = wd[NCH-1:0];
	wire [NCH-1:0] wd_src = wd[`SCMC_CFG_SRC +: NCH];
	wire [NCH-1:0] wd_rng = wd[`SCMC_CFG_RNG +: NCH];

	// ----------------------------------------
	// Supply state
	// ----------------------------------------
	// Under-voltage outranks over-voltage: it resets all configuration anyway
	always_comb begin
		case (st_q)
			scmc_pkg::SCMC_SUP_UV: st_d = uv_f ? st_q : scmc_pkg::SCMC_SUP_RUN;
			scmc_pkg::SCMC_SUP_RUN, scmc_pkg::SCMC_SUP_OV: st_d = uv_f ? scmc_pkg::SCMC_SUP_UV :
				(ov_f ? scmc_pkg::SCMC_SUP_OV : scmc_pkg::SCMC_SUP_RUN);
			default: st_d = scmc_pkg::SCMC_SUP_RUN;
		endcase
	end

	wire in_uv = st_q == scmc_pkg::SCMC_SUP_UV;
	wire in_ov = st_q == scmc_pkg::SCMC_SUP_OV;
	wire uv_enter = (st_d == scmc_pkg::SCMC_SUP_UV) & ~in_uv;
	wire ov_enter = (st_d == scmc_pkg::SCMC_SUP_OV) & ~in_ov;
	wire uv_exit = in_uv & (st_d != scmc_pkg::SCMC_SUP_UV);
	// Recovery from low supply resets the configuration as at power-up; fault flags and interrupt status are kept
	wire cfg_rst = reset | uv_exit;
	wire sup_ok = st_d == scmc_pkg::SCMC_SUP_RUN;
	always_ff @(posedge mclk) begin
		st_q <= reset ? scmc_pkg::SCMC_SUP_RUN : st_d;
	end

	// ----------------------------------------
	// Locked configuration fields
	// ----------------------------------------
	always_comb begin
		side_d = side_q;
		src_d = src_q;
		rng_d = rng_q;
		oc_d = oc_q;
		rej_side = 1'b0;
		rej_lock = 1'b0;
		if (wr && sel_cfg) begin
			for (int c = 0; c < NCH; c++) begin
				if (act_q[c]) begin
					rej_lock = rej_lock | (wd_side[c] != side_q[c]) |
						(wd_src[c] != src_q[c]) | (wd_rng[c] != rng_q[c]);
				end else begin
					side_d[c] = wd_side[c];
					src_d[c] = wd_src[c];
					rng_d[c] = wd_rng[c];
				end
			end
			for (int p = 0; p < NCH / 2; p++) begin
				// First high-side with second low-side is refused
				if (side_d[2*p] && !side_d[2*p+1]) begin
					side_d[2*p +: 2] = side_q[2*p +: 2];
					rej_side = 1'b1;
				end
			end
		end
		if (wr && sel_oc) begin
			for (int c = 0; c < NCH; c++) begin
				if (act_q[c]) begin
					rej_lock = rej_lock | (wd[2*c +: 2] != oc_q[2*c +: 2]);
				end else begin
					oc_d[2*c +: 2] = wd[2*c +: 2];
				end
			end
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (cfg_rst) begin
			side_q <= '0;
			src_q <= '0;
			rng_q <= '0;
			oc_q <= '0;
			ien_q <= '0;
		end else begin
			side_q <= side_d;
			src_q <= src_d;
			rng_q <= rng_d;
			oc_q <= oc_d;
			ien_q <= (wr && sel_ien) ? wd[`SCMC_IRQ_W-1:0] : ien_q;
		end
	end

	// Enables are dropped on over-voltage and must be written again
	always_ff @(posedge mclk) begin
		if (cfg_rst || ov_enter) begin
			en_q <= '0;
			drven_q <= '0;
			fspd_q <= 1'b0;
			pump_q <= 1'b0;
		end else begin
			if (wr && sel_svc) begin
				en_q <= wd[NCH-1:0];
				fspd_q <= wd[`SCMC_SVC_FSPD];
				pump_q <= wd[`SCMC_SVC_PUMP];
			end
			drven_q <= (wr && sel_drv) ? wd[NCH-1:0] : drven_q;
		end
	end

	// Targets stay writable while running
	always_ff @(posedge mclk) begin
		for (int c = 0; c < NCH; c++) begin
			if (cfg_rst) begin
				setpt_q[c*SPW +: SPW] <= '0;
				per_q[c] <= `SCMC_RST_PER;
			end else if (wr && tgt_hit(avs_address, c)) begin
				setpt_q[c*SPW +: SPW] <= wd[SPW-1:0];
				per_q[c] <= wd[`SCMC_TGT_PER +: SPW];
			end
		end
	end

	// ----------------------------------------
	// Fault flags and interrupts
	// ----------------------------------------
	always_comb begin
		ist_d = (wr && sel_iclr) ? ist_q & ~wd[`SCMC_IRQ_W-1:0] : ist_q;
		ist_d[`SCMC_IRQ_UV] = ist_d[`SCMC_IRQ_UV] | uv_enter;
		ist_d[`SCMC_IRQ_OV] = ist_d[`SCMC_IRQ_OV] | ov_enter;
		ist_d[`SCMC_IRQ_REJ] = ist_d[`SCMC_IRQ_REJ] | rej_side | rej_lock;
	end

	// Set beats clear-on-read so no fault is lost
	always_ff @(posedge mclk) begin
		if (reset) begin
			flt_q <= '0;
			ist_q <= '0;
			irq_q <= 1'b0;
		end else begin
			flt_q[`SCMC_FLT_OV] <= (flt_q[`SCMC_FLT_OV] & ~(rd & sel_flt)) | ov_enter;
			flt_q[`SCMC_FLT_UV] <= (flt_q[`SCMC_FLT_UV] & ~(rd & sel_flt)) | uv_enter;
			ist_q <= ist_d;
			irq_q <= |(ist_d & ien_q);
		end
	end

	// ----------------------------------------
	// Channel activation and drive
	// ----------------------------------------
	wire wd_ok = ~config_pin | wd_permit;
	wire gate_ok = endr_f & wd_ok & sup_ok;

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			act_d[c] = en_q[c] & drven_q[c] & gate_ok;
			drv[c] = src_q[c] ? channel_drive_input[c] : pwm_q[c];
			// Opposite transistor recirculates while active
			hs_q[c] = act_d[c] & (side_q[c] ? drv[c] : ~drv[c]);
			ls_q[c] = act_d[c] & (side_q[c] ? ~drv[c] : drv[c]);
		end
	end

	// Period restarts together for channels enabled in the same write
	always_ff @(posedge mclk) begin
		for (int c = 0; c < NCH; c++) begin
			if (reset || !act_d[c]) begin
				pcnt_q[c] <= '0;
				pwm_q[c] <= 1'b0;
			end else if (!act_q[c] || pcnt_q[c] == '0) begin
				pcnt_q[c] <= per_q[c] - 1'b1;
				pwm_q[c] <= current_low[c];
			end else begin
				pcnt_q[c] <= pcnt_q[c] - 1'b1;
				if (!current_low[c]) begin
					pwm_q[c] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			act_q <= '0;
			hs_out_q <= '0;
			ls_out_q <= '0;
			clamp_q <= 1'b0;
		end else begin
			act_q <= act_d;
			hs_out_q <= hs_q;
			ls_out_q <= ls_q;
			clamp_q <= sup_ok;
		end
	end

	// ----------------------------------------
	// Avalon slave
	// ----------------------------------------
	always_comb begin
		rd_mux = '0;
		if (sel_flt) begin
			rd_mux[`SCMC_FLT_UV:`SCMC_FLT_OV] = flt_q;
		end else if (sel_svc) begin
			rd_mux[NCH-1:0] = en_q;
			rd_mux[`SCMC_SVC_FSPD] = fspd_q;
			rd_mux[`SCMC_SVC_PUMP] = pump_q;
		end else if (sel_drv) begin
			rd_mux[NCH-1:0] = drven_q;
		end else if (sel_cfg) begin
			rd_mux[NCH-1:0] = side_q;
			rd_mux[`SCMC_CFG_SRC +: NCH] = src_q;
			rd_mux[`SCMC_CFG_RNG +: NCH] = rng_q;
		end else if (sel_oc) begin
			rd_mux[2*NCH-1:0] = oc_q;
		end else if (sel_stat) begin
			rd_mux[NCH-1:0] = act_q;
			rd_mux[`SCMC_STAT_UV] = in_uv;
			rd_mux[`SCMC_STAT_OV] = in_ov;
			rd_mux[`SCMC_STAT_ENDR] = endr_f;
		end else if (sel_ist) begin
			rd_mux[`SCMC_IRQ_W-1:0] = ist_q;
		end else if (sel_ien) begin
			rd_mux[`SCMC_IRQ_W-1:0] = ien_q;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (tgt_hit(avs_address, c)) begin
					rd_mux[SPW-1:0] = setpt_q[c*SPW +: SPW];
					rd_mux[`SCMC_TGT_PER +: SPW] = per_q[c];
				end
			end
		end
	end

	// One wait cycle keeps every answer registered
	always_ff @(posedge mclk) begin
		if (reset) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else if ((avs_read || avs_write) && wait_q) begin
			wait_q <= 1'b0;
			rdata_q <= avs_read ? rd_mux : 32'h00000000;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign irq = irq_q;
	assign ch_active = act_q;
	assign hs_gate = hs_out_q;
	assign ls_gate = ls_out_q;
	assign fs_predrv_en = fspd_q;
	assign pump_predrv_en = pump_q;
	assign ls_clamp_en = clamp_q;
	assign cur_range = rng_q;
	assign oc_thresh = oc_q;
	assign tgt_current = setpt_q;
endmodule

// ===== dv/scmc_assertions.sv
`timescale 1ns/10ps
// ---
// Checker
// ---
module scmc_chk #(
	parameter int NCH = 6
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic supply_undervoltage,
	input wire logic supply_overvoltage,
	input wire logic driver_enable_input,
	input wire logic config_pin,
	input wire logic wd_permit,
	input wire logic [NCH-1:0] ch_active,
	input wire logic [NCH-1:0] hs_gate,
	input wire logic [NCH-1:0] ls_gate,
	input wire logic fs_predrv_en,
	input wire logic pump_predrv_en,
	input wire logic ls_clamp_en
);
	// Saturating run lengths, sized for the longest filter
	logic [11:0] uv_q, ov_q, el_q;
	always_ff @(posedge mclk) begin
		uv_q <= (reset || !supply_undervoltage) ? 12'h000 : uv_q + 12'(uv_q != 12'hFFF);
		ov_q <= (reset || !supply_overvoltage) ? 12'h000 : ov_q + 12'(ov_q != 12'hFFF);
		el_q <= (reset || driver_enable_input) ? 12'h000 : el_q + 12'(el_q != 12'hFFF);
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_idle_gates: assert property (((hs_gate | ls_gate) & ~ch_active) == '0)
		else $error("gate on for idle channel");
	chk_gate_pair: assert property (((hs_gate ^ ls_gate) & ch_active) == ch_active)
		else $error("drive and recirculation not opposite");
	chk_fault_filter: assert property ($fell(ls_clamp_en) |->
		uv_q >= 12'h0F9 || ov_q >= 12'h9C3)
		else $error("supply fault taken before filter");
	chk_uv_off: assert property (uv_q == 12'h104 |-> !ls_clamp_en && ch_active == '0)
		else $error("under-voltage left outputs on");
	chk_ov_off: assert property (ov_q == 12'h9CE |->
		!ls_clamp_en && !fs_predrv_en && !pump_predrv_en && ch_active == '0)
		else $error("over-voltage left outputs on");
	chk_endr_off: assert property (el_q == 12'h01E |-> ch_active == '0)
		else $error("channel active with enable input low");
	chk_wd_gate: assert property ((ch_active & ~$past(ch_active)) != '0 |->
		!$past(config_pin) || $past(wd_permit))
		else $error("channel started without watchdog permit");
	cover property (&ch_active);
	cover property ($fell(ls_clamp_en));
	cover property (irq);
	cover property (avs_read && !avs_waitrequest);
endmodule

// ===== dv/scmc_load.sv
`timescale 1ns/10ps
// ---
// Solenoid load
// ---
module scmc_load #(
	parameter int NCH = 6
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic slow,
	input wire logic [NCH-1:0] side,
	input wire logic [NCH-1:0] hs_gate,
	input wire logic [NCH-1:0] ls_gate,
	output logic [NCH-1:0] current_low
);
	// Coarse current level; slow halves the slew to stress the loop
	logic [3:0] lvl_q [NCH];
	logic tick_q;
	logic [NCH-1:0] on;
	assign on = (side & hs_gate) | (~side & ls_gate);
	always_ff @(posedge mclk) begin
		tick_q <= reset ? 1'b1 : !tick_q || !slow;
		for (int i = 0; i < NCH; i++) begin
			if (reset)
				lvl_q[i] <= 4'h0;
			else if (tick_q && on[i] && lvl_q[i] != 4'hF)
				lvl_q[i] <= lvl_q[i] + 4'h1;
			else if (tick_q && !on[i] && lvl_q[i] != 4'h0)
				lvl_q[i] <= lvl_q[i] - 4'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < NCH; i++)
			current_low[i] = lvl_q[i] < 4'h8;
	end
endmodule

// ===== dv/scmc_top_tb.sv
`timescale 1ns/10ps
// ---
// Bench
// ---
module scmc_top_tb;
	localparam int NCH = 6;
	localparam int SPW = 11;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic supply_undervoltage = 1'b0;
	logic supply_overvoltage = 1'b0;
	logic driver_enable_input = 1'b1;
	logic config_pin = 1'b0;
	logic wd_permit = 1'b1;
	logic slow = 1'b0;
	logic [NCH-1:0] channel_drive_input = 6'h00;
	logic [NCH-1:0] load_side = 6'h00;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, irq, fs_predrv_en, pump_predrv_en, ls_clamp_en;
	logic [NCH-1:0] current_low, ch_active, hs_gate, ls_gate, cur_range;
	logic [2*NCH-1:0] oc_thresh;
	logic [NCH*SPW-1:0] tgt_current;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int on_cnt;
	always #20 mclk = ~mclk;
	scmc_top #(.NCH(NCH), .SPW(SPW)) u_scmc_top (.mclk, .reset, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .supply_undervoltage,
		.supply_overvoltage, .driver_enable_input, .config_pin, .wd_permit, .channel_drive_input,
		.current_low, .ch_active, .hs_gate, .ls_gate, .fs_predrv_en, .pump_predrv_en,
		.ls_clamp_en, .cur_range, .oc_thresh, .tgt_current);
	scmc_load #(.NCH(NCH)) u_scmc_load (.mclk, .reset, .slow, .side(load_side), .hs_gate,
		.ls_gate, .current_low);
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// A hang counts as a mismatch
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 32'h4E20) begin
			err_count = err_count + 1;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk);
	endtask
	initial begin
		cycles(10);
		reset <= 1'b0;
		rdchk("config", 8'h0C, 32'h0);
		rdchk("period", 8'h40, 32'h000C_0000);
		rdchk("unmapped", 8'h30, 32'h0);
		cycles(30);
		rdchk("status", 8'h14, 32'h0000_0400);
		$display("reset test done");
		bus(1'b1, 8'h20, 32'h7);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 8'h0C, 32'(k));
			rdchk("pair", 8'h0C, (k == 1) ? 32'h0 : 32'(k));
		end
		rdchk("irq status", 8'h18, 32'h4);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(1'b1, 8'h20, 32'h0);
		cycles(2);
		chk("irq masked", {31'h0, irq}, 32'h0);
		bus(1'b1, 8'h1C, 32'h4);
		rdchk("irq cleared", 8'h18, 32'h0);
		bus(1'b1, 8'h20, 32'h7);
		bus(1'b1, 8'h0C, 32'h0001_0402);
		bus(1'b1, 8'h10, 32'h0000_0FFF);
		load_side <= 6'h02;
		cycles(2);
		chk("range", {26'h0, cur_range}, 32'h1);
		chk("oc", {20'h0, oc_thresh}, 32'hFFF);
		$display("pair test done");
		config_pin <= 1'b1;
		wd_permit <= 1'b0;
		bus(1'b1, 8'h08, 32'h3F);
		bus(1'b1, 8'h04, 32'hFF);
		cycles(4);
		chk("wd hold", {26'h0, ch_active}, 32'h0);
		bus(1'b1, 8'h04, 32'hC0);
		wd_permit <= 1'b1;
		bus(1'b1, 8'h04, 32'hFF);
		while (ch_active === 6'h00) @(posedge mclk);
		chk("start", {26'h0, ch_active}, 32'h3F);
		chk("predrv", {30'h0, fs_predrv_en, pump_predrv_en}, 32'h3);
		$display("start test done");
		bus(1'b1, 8'h0C, 32'h0);
		rdchk("locked", 8'h0C, 32'h0001_0402);
		bus(1'b1, 8'h10, 32'h0);
		chk("oc locked", {20'h0, oc_thresh}, 32'hFFF);
		bus(1'b1, 8'h40, 32'h0014_07FF);
		bus(1'b1, 8'h44, 32'h0010_0123);
		rdchk("set point", 8'h40, 32'h0014_07FF);
		chk("targets", {10'h0, tgt_current[21:0]}, {10'h0, 11'h123, 11'h7FF});
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			on_cnt = 0;
			repeat (200) begin
				@(posedge mclk);
				on_cnt += ls_gate[0];
			end
			chk("pwm", 32'(on_cnt > 0 && on_cnt < 200), 32'h1);
		end
		channel_drive_input <= 6'h04;
		cycles(3);
		chk("pin on", {30'h0, hs_gate[2], ls_gate[2]}, 32'h1);
		channel_drive_input <= 6'h00;
		cycles(3);
		chk("pin off", {30'h0, hs_gate[2], ls_gate[2]}, 32'h2);
		driver_enable_input <= 1'b0;
		cycles(10);
		chk("glitch", {26'h0, ch_active}, 32'h3F);
		cycles(25);
		chk("endr off", {26'h0, ch_active}, 32'h0);
		driver_enable_input <= 1'b1;
		cycles(30);
		chk("endr on", {26'h0, ch_active}, 32'h3F);
		$display("run test done");
		supply_overvoltage <= 1'b1;
		cycles(2400);
		chk("ov early", {26'h0, ch_active}, 32'h3F);
		cycles(200);
		chk("ov outs", {23'h0, ch_active, fs_predrv_en, pump_predrv_en, ls_clamp_en}, 32'h0);
		supply_overvoltage <= 1'b0;
		cycles(2600);
		rdchk("ov flag", 8'h00, 32'h2);
		rdchk("ov cleared", 8'h00, 32'h0);
		rdchk("svc cleared", 8'h04, 32'h0);
		rdchk("drv cleared", 8'h08, 32'h0);
		rdchk("irq ov", 8'h18, 32'h6);
		chk("irq ov", {31'h0, irq}, 32'h1);
		bus(1'b1, 8'h1C, 32'h6);
		bus(1'b1, 8'h08, 32'h3F);
		bus(1'b1, 8'h04, 32'hFF);
		cycles(3);
		chk("rewrite", {26'h0, ch_active}, 32'h3F);
		$display("ov test done");
		supply_undervoltage <= 1'b1;
		cycles(200);
		chk("uv early", {26'h0, ch_active}, 32'h3F);
		cycles(100);
		chk("uv outs", {25'h0, ch_active, ls_clamp_en}, 32'h0);
		supply_undervoltage <= 1'b0;
		cycles(300);
		rdchk("uv flag", 8'h00, 32'h4);
		rdchk("cfg reset", 8'h0C, 32'h0);
		rdchk("per reset", 8'h40, 32'h000C_0000);
		rdchk("irqen reset", 8'h20, 32'h0);
		$display("uv test done");
		end_of_test();
	end
endmodule
bind scmc_top scmc_chk #(.NCH(NCH)) u_scmc_chk (.mclk, .reset, .avs_read, .avs_write,
	.avs_waitrequest, .irq, .supply_undervoltage, .supply_overvoltage, .driver_enable_input,
	.config_pin, .wd_permit, .ch_active, .hs_gate, .ls_gate, .fs_predrv_en, .pump_predrv_en,
	.ls_clamp_en);
